// [logic/motor_ctrl_pkg.sv]
// Shared constants for the motor driver configuration register bank.
// Assumes an 8-bit register map reached over a 16-bit serial frame.
package motor_ctrl_pkg;
   // Register offsets on the serial link
   localparam logic [5:0] ADDR_STATUS = 6'h02;   // Serial fault flags, read only
   localparam logic [5:0] ADDR_LOCK   = 6'h03;   // Lock control
   localparam logic [5:0] ADDR_DRIVE  = 6'h04;   // Drive configuration
   localparam logic [5:0] ADDR_PROT   = 6'h05;   // Protection and pin reporting
   // Values after reset
   localparam logic [7:0] RST_LOCK    = 8'h00;
   localparam logic [7:0] RST_DRIVE   = 8'h60;
   localparam logic [7:0] RST_PROT    = 8'h46;
   // Writable bits; read-only reserved and self-clearing bits stay zero
   localparam logic [7:0] MASK_LOCK   = 8'h07;
   localparam logic [7:0] MASK_DRIVE  = 8'hFE;
   localparam logic [7:0] MASK_PROT   = 8'h7F;
   // Lock field patterns
   localparam logic [2:0] LOCK_OPEN   = 3'h3;
   localparam logic [2:0] LOCK_CLOSE  = 3'h6;
   // Field positions
   localparam int CLEAR_BIT   = 0;   // Fault clear command in drive register
   localparam int SCHEME_LSB  = 1;   // Drive scheme, two bits
   localparam int SLEW_LSB    = 3;   // Slew select, two bits
   localparam int SDO_BIT     = 5;   // Serial out driver select
   localparam int DUTY_BIT    = 4;   // Full duty frequency select
   localparam int OVSEL_BIT   = 3;   // Overvoltage threshold select
   localparam int OVEN_BIT    = 2;   // Overvoltage protect enable
   localparam int SPIREP_BIT  = 1;   // Serial fault pin report disable
   localparam int OTWREP_BIT  = 0;   // Overtemp warning pin report
   localparam int ADDRFLT_BIT = 0;   // Address fault flag in status
   localparam int SCLKFLT_BIT = 1;   // Clock framing fault flag in status
   // Frame layout
   localparam int RW_BIT      = 15;  // One means read
   localparam int ADDR_MSB    = 14;
   localparam int ADDR_LSB    = 9;
   localparam logic [4:0] FRAME_LAST = 5'h0F;   // Count at the sixteenth edge
   localparam logic [4:0] FRAME_OVER = 5'h10;   // Count at a seventeenth edge
   localparam logic [4:0] DATA_START = 5'h08;   // First reply data bit

   // Frame tracking in the system clock domain
   typedef enum logic [1:0] {
      F_IDLE   = 2'b00,
      F_ACTIVE = 2'b01,
      F_SETTLE = 2'b10,
      F_COMMIT = 2'b11
   } frame_state_t;

   // Addresses that this bank answers
   function automatic logic userAddr(input logic [5:0] a);
      return (a == ADDR_STATUS) || (a == ADDR_LOCK) || (a == ADDR_DRIVE) || (a == ADDR_PROT);
   endfunction

   // Read data for an address; unknown addresses read zero
   function automatic logic [7:0] pickReg(input logic [5:0] a, input logic [7:0] st,
                                          input logic [7:0] lk, input logic [7:0] dr,
                                          input logic [7:0] pr);
      logic [7:0] r;
      r = 8'h00;
      if (userAddr(a)) begin
         if (a == ADDR_STATUS) r = st;
         else if (a == ADDR_LOCK) r = lk;
         else if (a == ADDR_DRIVE) r = dr;
         else r = pr;
      end
      return r;
   endfunction
endpackage

// [logic/serial_link_if.sv]
// Carrier between the serial clock side and the register core.
// Bank values are held still by the core while a frame runs.
`timescale 1ns/1ps
interface serial_link_if;
   logic [15:0] frameWord;     // Last full frame received
   logic        doneToggle;    // Flips when sixteen bits are in
   logic        overToggle;    // Flips on a seventeenth edge
   logic [7:0]  bankStat;      // Status byte for the reply
   logic [7:0]  bankLock;      // Lock register snapshot
   logic [7:0]  bankDrive;     // Drive register snapshot
   logic [7:0]  bankProt;      // Protection register snapshot
   logic        pushPull;      // Serial out driver select
   modport link (output frameWord, doneToggle, overToggle,
                 input bankStat, bankLock, bankDrive, bankProt, pushPull);
   modport core (input frameWord, doneToggle, overToggle,
                 output bankStat, bankLock, bankDrive, bankProt, pushPull);
endinterface

// [logic/serial_link.sv]
// Serial shift logic running on the host's serial clock.
// Assumes the clock idles while chip select is high; chip select clears the frame.
`timescale 1ns/1ps
module serial_link
   import motor_ctrl_pkg::*;
(
   input  wire logic  sclk,      // Serial clock from the host
   input  wire logic  rst_n,     // System reset, active low
   input  wire logic  csN,       // Chip select, active low
   input  wire logic  mosi,      // Serial data in
   output logic       sdo,       // Serial data out value
   output logic       sdoOeN,    // Serial data out enable, low drives
   serial_link_if.link lnk       // Frame and bank carrier
);
   logic [4:0]  count;           // Edges seen in this frame
   logic [14:0] shiftIn;         // Bits received so far
   logic [7:0]  readByte;        // Reply data held for the frame
   logic [7:0]  pick;            // Read data for the decoded address
   logic        nextBit;         // Reply bit for the next half period

   // Shift in on rising edges; chip select high restarts the frame
   always_ff @(posedge sclk or posedge csN) begin
      if (csN) begin
         count   <= 5'h00;
         shiftIn <= 15'h0000;
      end else begin
         shiftIn <= {shiftIn[13:0], mosi};
         if (count != 5'h1F) count <= count + 5'h01;   // Saturate, never wraps to valid
      end
   end

   // Word and events kept across frames, so only system reset clears them
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         lnk.frameWord  <= 16'h0000;
         lnk.doneToggle <= 1'b0;
         lnk.overToggle <= 1'b0;
      end else if (!csN) begin
         if (count == FRAME_LAST) begin
            lnk.frameWord  <= {shiftIn, mosi};
            lnk.doneToggle <= ~lnk.doneToggle;
         end
         if (count == FRAME_OVER) lnk.overToggle <= ~lnk.overToggle;
      end
   end

   // Address is whole once eight bits are in
   assign pick = pickReg(shiftIn[6:1], lnk.bankStat, lnk.bankLock, lnk.bankDrive,
                         lnk.bankProt);

   // Reply: status byte, then the addressed register
   always_comb begin
      if (count >= 5'h10) nextBit = 1'b0;
      else if (!count[3]) nextBit = lnk.bankStat[~count[2:0]];
      else if (count == DATA_START) nextBit = pick[7];
      else nextBit = readByte[~count[2:0]];
   end

   // Drive on falling edges; open drain only pulls low
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         sdo      <= 1'b0;
         sdoOeN   <= 1'b1;
         readByte <= 8'h00;
      end else begin
         if (count == DATA_START) readByte <= pick;
         sdo    <= lnk.pushPull ? nextBit : 1'b0;
         sdoOeN <= lnk.pushPull ? 1'b0 : nextBit;
      end
   end
endmodule

// [logic/motor_driver_control_regs.sv]
// Configuration register bank of a three-phase motor driver, with its serial port.
// Assumes a 40 MHz system clock and a slower, unrelated serial clock from the host.
`timescale 1ns/1ps
module motor_driver_control_regs
   import motor_ctrl_pkg::*;
(
   input  wire logic       clk,                         // System clock, 40 MHz
   input  wire logic       rst_n,                       // Asynchronous reset, active low
   input  wire logic       sclk,                        // Serial clock from host
   input  wire logic       csN,                         // Serial chip select, active low
   input  wire logic       mosi,                        // Serial data in
   input  wire logic       overtempWarning,             // Overtemperature warning level
   output logic            sdo,                         // Serial data out value
   output logic            sdoOeN,                      // Serial out enable, low drives
   output logic [1:0]      driveScheme,                 // Input scheme select
   output logic [1:0]      slewSelect,                  // Output slew rate select
   output logic            fullDutyFreqSel,             // 0 is 20 kHz, 1 is 40 kHz
   output logic            overvoltageThresholdSelect,  // 0 is 34 V, 1 is 22 V
   output logic            overvoltageProtectEnable,    // Protection on when high
   output logic            faultClearPulse,             // One cycle, clears latched faults
   output logic            configLocked,                // Writes locked out
   output logic            faultPinN                    // Fault pin, active low
);
   serial_link_if lnk ();                               // Carrier to the serial side

   logic         csMeta;          // Chip select, first stage
   logic         csSync;          // Chip select, synchronised
   logic         doneMeta;        // Done toggle, first stage
   logic         doneSync;        // Done toggle, synchronised
   logic         doneLast;        // Done toggle, previous
   logic         overMeta;        // Overrun toggle, first stage
   logic         overSync;        // Overrun toggle, synchronised
   logic         overLast;        // Overrun toggle, previous
   logic         otwMeta;         // Warning, first stage
   logic         otwSync;         // Warning, synchronised
   frame_state_t state;           // Frame tracker
   logic         gotWord;         // Sixteen bits seen this frame
   logic         gotOver;         // Too many bits this frame
   logic [15:0]  wordHold;        // Frame taken from the serial side
   logic [7:0]   lockReg;         // Lock register contents
   logic [7:0]   driveReg;        // Drive register contents
   logic [7:0]   protReg;         // Protection register contents
   logic         addrFlag;        // Address fault flag
   logic         sclkFlag;        // Clock framing fault flag
   logic         doneEdge;        // New word arrived
   logic         overEdge;        // Overrun arrived
   logic [5:0]   addr;            // Frame address
   logic [7:0]   wd;              // Frame write data
   logic         commitOk;        // Well-framed frame being acted on
   logic         wrEn;            // Write to a known address
   logic         wrLock;          // Write to the lock register
   logic         wrDrive;         // Accepted write to drive register
   logic         wrProt;          // Accepted write to protection register
   logic         setAddr;         // Address fault event
   logic         setSclk;         // Framing fault event
   logic         clrFlags;        // Fault clear command accepted

   serial_link u_link (
      .sclk   (sclk),
      .rst_n  (rst_n),
      .csN    (csN),
      .mosi   (mosi),
      .sdo    (sdo),
      .sdoOeN (sdoOeN),
      .lnk    (lnk.link)
   );

   // Two-flop synchronisers for pins and serial-side events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         csMeta   <= 1'b1;
         csSync   <= 1'b1;
         doneMeta <= 1'b0;
         doneSync <= 1'b0;
         doneLast <= 1'b0;
         overMeta <= 1'b0;
         overSync <= 1'b0;
         overLast <= 1'b0;
         otwMeta  <= 1'b0;
         otwSync  <= 1'b0;
      end else begin
         csMeta   <= csN;
         csSync   <= csMeta;
         doneMeta <= lnk.doneToggle;
         doneSync <= doneMeta;
         doneLast <= doneSync;
         overMeta <= lnk.overToggle;
         overSync <= overMeta;
         overLast <= overSync;
         otwMeta  <= overtempWarning;
         otwSync  <= otwMeta;
      end
   end

   assign doneEdge = doneSync ^ doneLast;
   assign overEdge = overSync ^ overLast;

   // Frame tracker; settle cycle lets a late toggle land before the verdict
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= F_IDLE;
      end else begin
         unique case (state)
            F_IDLE:   if (!csSync) state <= F_ACTIVE;
            F_ACTIVE: if (csSync) state <= F_SETTLE;
            F_SETTLE: state <= F_COMMIT;
            F_COMMIT: state <= F_IDLE;
         endcase
      end
   end

   // Per-frame bookkeeping of what the serial side reported
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gotWord  <= 1'b0;
         gotOver  <= 1'b0;
         wordHold <= 16'h0000;
      end else if (state == F_IDLE) begin
         gotWord <= 1'b0;
         gotOver <= 1'b0;
      end else if (state != F_COMMIT) begin
         if (doneEdge) begin
            gotWord  <= 1'b1;
            wordHold <= lnk.frameWord;    // Word is still until the next frame
         end
         if (overEdge) gotOver <= 1'b1;
      end
   end

   // Decode of the frame being committed
   assign addr     = wordHold[ADDR_MSB:ADDR_LSB];
   assign wd       = wordHold[7:0];
   assign commitOk = (state == F_COMMIT) && gotWord && !gotOver;
   assign setSclk  = (state == F_COMMIT) && (!gotWord || gotOver);
   assign setAddr  = commitOk && !userAddr(addr);
   assign wrEn     = commitOk && !wordHold[RW_BIT] && userAddr(addr);
   assign wrLock   = wrEn && (addr == ADDR_LOCK);
   assign wrDrive  = wrEn && (addr == ADDR_DRIVE) && !configLocked;
   assign wrProt   = wrEn && (addr == ADDR_PROT) && !configLocked;
   assign clrFlags = wrDrive && wd[CLEAR_BIT];

   // Lock field: stored as written, lock state changes on two patterns only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lockReg      <= RST_LOCK;
         configLocked <= 1'b0;
      end else if (wrLock) begin
         lockReg <= wd & MASK_LOCK;
         if (wd[2:0] == LOCK_OPEN) configLocked <= 1'b0;
         else if (wd[2:0] == LOCK_CLOSE) configLocked <= 1'b1;
      end
   end

   // Drive register; the clear bit is never stored, so it reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) driveReg <= RST_DRIVE;
      else if (wrDrive) driveReg <= wd & MASK_DRIVE;
   end

   // Protection register; top bit is read-only zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) protReg <= RST_PROT;
      else if (wrProt) protReg <= wd & MASK_PROT;
   end

   // Serial fault flags; a new fault in the clearing cycle survives
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addrFlag <= 1'b0;
         sclkFlag <= 1'b0;
      end else begin
         addrFlag <= (addrFlag && !clrFlags) || setAddr;
         sclkFlag <= (sclkFlag && !clrFlags) || setSclk;
      end
   end

   // Clear command pulse to the other latched faults of the device
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) faultClearPulse <= 1'b0;
      else faultClearPulse <= clrFlags;
   end

   // Fault pin from serial faults and the overtemperature warning
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) faultPinN <= 1'b1;
      else faultPinN <= !(((addrFlag || sclkFlag) && !protReg[SPIREP_BIT])
                           || (otwSync && protReg[OTWREP_BIT]));
   end

   // Snapshot for the serial side, frozen while chip select is low.
   // Trade-off: a frame reads state as of its start, never a torn value.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk.bankStat  <= 8'h00;
         lnk.bankLock  <= RST_LOCK;
         lnk.bankDrive <= RST_DRIVE;
         lnk.bankProt  <= RST_PROT;
         lnk.pushPull  <= RST_DRIVE[SDO_BIT];
      end else if (state == F_IDLE && csSync) begin
         lnk.bankStat  <= 8'h00;
         lnk.bankStat[ADDRFLT_BIT] <= addrFlag;
         lnk.bankStat[SCLKFLT_BIT] <= sclkFlag;
         lnk.bankLock  <= lockReg;
         lnk.bankDrive <= driveReg;
         lnk.bankProt  <= protReg;
         lnk.pushPull  <= driveReg[SDO_BIT];
      end
   end

   // Configuration outputs straight from the register flops
   assign driveScheme                = driveReg[SCHEME_LSB +: 2];
   assign slewSelect                 = driveReg[SLEW_LSB +: 2];
   assign fullDutyFreqSel            = protReg[DUTY_BIT];
   assign overvoltageThresholdSelect = protReg[OVSEL_BIT];
   assign overvoltageProtectEnable   = protReg[OVEN_BIT];

   // Checks, all on the system clock
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_unlock;
      wrLock && (wd[2:0] == LOCK_OPEN) |=> !configLocked ##1 lockReg[2:0] == LOCK_OPEN;
   endproperty
   a_unlock: assert property (p_unlock) else $error("Unlock pattern did not unlock");

   property p_locked_ignore;
      configLocked && wrEn && (addr != ADDR_LOCK) |=> $stable(driveReg) && $stable(protReg);
   endproperty
   a_locked_ignore: assert property (p_locked_ignore) else $error("Write passed lock");

   property p_lock_keep;
      wrLock && (wd[2:0] != LOCK_OPEN) && (wd[2:0] != LOCK_CLOSE) |=> $stable(configLocked);
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("Lock state changed");

   property p_clear;
      clrFlags && !setAddr |=> !addrFlag && faultClearPulse ##1 !faultClearPulse;
   endproperty
   a_clear: assert property (p_clear) else $error("Fault clear misbehaved");

   property p_scheme;
      wrDrive |=> driveScheme == $past(wd[2:1]) && !driveReg[CLEAR_BIT];
   endproperty
   a_scheme: assert property (p_scheme) else $error("Drive scheme not taken");

   property p_slew;
      wrDrive |=> slewSelect == $past(wd[4:3]);
   endproperty
   a_slew: assert property (p_slew) else $error("Slew not taken");

   property p_prot;
      wrProt |=> fullDutyFreqSel == $past(wd[4]) && overvoltageThresholdSelect == $past(wd[3])
                 && overvoltageProtectEnable == $past(wd[2]);
   endproperty
   a_prot: assert property (p_prot) else $error("Protection fields not taken");

   property p_serial_masked;
      (addrFlag || sclkFlag) && protReg[SPIREP_BIT] && !(otwSync && protReg[OTWREP_BIT])
         |=> faultPinN;
   endproperty
   a_serial_masked: assert property (p_serial_masked) else $error("Masked fault on pin");

   property p_otw_report;
      otwSync && protReg[OTWREP_BIT] |=> !faultPinN;
   endproperty
   a_otw_report: assert property (p_otw_report) else $error("Warning not on pin");

   property p_addr_fault;
      (state == F_COMMIT) && gotWord && !gotOver && !userAddr(addr) |=> addrFlag;
   endproperty
   a_addr_fault: assert property (p_addr_fault) else $error("Address fault missed");

   property p_frame_fault;
      (state == F_SETTLE) && !gotWord && !doneEdge |-> ##2 sclkFlag;
   endproperty
   a_frame_fault: assert property (p_frame_fault) else $error("Framing fault missed");

   property p_lock_close;
      wrLock && (wd[2:0] == LOCK_CLOSE) |=> configLocked;
   endproperty
   a_lock_close: assert property (p_lock_close) else $error("Lock pattern did not lock");

   property p_reply_mode;
      (state == F_IDLE) && csSync |=> lnk.pushPull == $past(driveReg[SDO_BIT]);
   endproperty
   a_reply_mode: assert property (p_reply_mode) else $error("Reply driver mode stale");
endmodule

// [verif/spi_host_model.sv]
// Serial host model: sends one frame of n edges per call and collects the reply line.
// Assumes the bench resolves the reply line, with a pull-up while it is released.
`timescale 1ns/1ps
module spi_host_model (
   output logic      sclk,     // Serial clock, still outside frames
   output logic      csN,      // Chip select, active low
   output logic      mosi,     // Serial data to the device
   input  wire logic sdoLine   // Resolved reply line
);
   // Idle levels: clock low, chip select high
   // Set in the update region, so the link logic, already waiting, sees the select edge
   initial begin
      sclk <= 1'b0;
      csN  <= 1'b1;
      mosi <= 1'b1;
   end

   // One frame of n edges at a 160 ns period; n other than 16 is a framing fault
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rep);
      rep = 16'h0000;
      csN = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         mosi = w[15 - (i % 16)];   // Shift on falling, device samples rising
         #80 sclk = 1'b1;
         rep = {rep[14:0], sdoLine};
         #80 sclk = 1'b0;
      end
      #80 csN = 1'b1;
      mosi = ~mosi;   // Released data line shows no stale value
      #400;   // Gap lets the core commit before the next frame
   endtask
endmodule

// [verif/tb_top.sv]
// Bench for the motor driver register bank, driven over its serial port.
// Assumes a 40 MHz system clock and the host model for all serial traffic.
`timescale 1ns/1ps
module tb_top
   import motor_ctrl_pkg::*;
   ;
   logic       clk = 1'b0, rst_n = 1'b1, overtempWarning = 1'b0;   // Bench driven
   logic       sclk, csN, mosi, sdo, sdoOeN, sdoLine;              // Serial pins
   logic [1:0] driveScheme, slewSelect;                            // Drive outputs
   logic       fullDutyFreqSel, overvoltageThresholdSelect, overvoltageProtectEnable;
   logic       faultClearPulse, configLocked, faultPinN;           // Status outputs
   int         error_cnt = 0, n_tests = 0, pulseCnt = 0, odBad = 0;
   logic       odMode = 1'b0;                                      // Open drain expected

   always #12.5 clk = ~clk;
   assign sdoLine = sdoOeN ? 1'b1 : sdo;   // Pull-up on the reply line

   motor_driver_control_regs u_motor_driver_control_regs (
      .clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .mosi(mosi),
      .overtempWarning(overtempWarning), .sdo(sdo), .sdoOeN(sdoOeN),
      .driveScheme(driveScheme), .slewSelect(slewSelect), .fullDutyFreqSel(fullDutyFreqSel),
      .overvoltageThresholdSelect(overvoltageThresholdSelect),
      .overvoltageProtectEnable(overvoltageProtectEnable), .faultClearPulse(faultClearPulse),
      .configLocked(configLocked), .faultPinN(faultPinN));
   spi_host_model u_spi_host_model (.sclk(sclk), .csN(csN), .mosi(mosi), .sdoLine(sdoLine));

   // Count clear pulses; watch for a driven high in open drain mode
   always @(posedge clk) if (faultClearPulse === 1'b1) pulseCnt <= pulseCnt + 1;
   always @(posedge sclk) if (odMode && sdoOeN === 1'b0 && sdo !== 1'b0) odBad <= odBad + 1;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [15:0] r;
      u_spi_host_model.xfer({1'b0, a, 1'b0, d}, 16, r);
   endtask
   // Read a register and compare its reply byte
   task automatic rc(input logic [5:0] a, input logic [7:0] exp, input string what);
      logic [15:0] r;
      u_spi_host_model.xfer({1'b1, a, 1'b0, 8'h00}, 16, r);
      chk(r[7:0], exp, what);
   endtask

   task automatic t_reset();
      rc(ADDR_LOCK, 8'h00, "lock reset");
      rc(ADDR_DRIVE, 8'h60, "drive reset");
      rc(ADDR_PROT, 8'h46, "prot reset");
      chk({7'h0, overvoltageProtectEnable}, 8'h01, "protect on");
      chk({7'h0, faultPinN}, 8'h01, "pin idle");
      $display("test reset done");
   endtask
   task automatic t_fields();
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_DRIVE, 8'h60 | 8'(i * 2 + (3 - i) * 8));
         chk({6'h0, driveScheme}, 8'(i), "scheme");
         chk({6'h0, slewSelect}, 8'(3 - i), "slew");
      end
      wr(ADDR_PROT, 8'hDD);
      rc(ADDR_PROT, 8'h5D, "prot top bit read only");
      chk({5'h0, fullDutyFreqSel, overvoltageThresholdSelect, overvoltageProtectEnable},
          8'h07, "prot set");
      wr(ADDR_PROT, 8'h40);
      chk({5'h0, fullDutyFreqSel, overvoltageThresholdSelect, overvoltageProtectEnable},
          8'h00, "prot clear");
      wr(ADDR_PROT, 8'h46);
      $display("test fields done");
   endtask
   // Every lock code, rising then falling; codes 3 to 6 from unlocked and from locked
   task automatic t_lock();
      int   v;
      logic e;
      e = 1'b0;
      for (int k = 0; k < 16; k++) begin
         v = (k < 8) ? k : 15 - k;
         wr(ADDR_LOCK, 8'(v));
         if (v == 3) e = 1'b0;
         else if (v == 6) e = 1'b1;
         chk({7'h0, configLocked}, {7'h0, e}, "lock state");
         if (k == 8) begin
            wr(ADDR_DRIVE, 8'h60);
            rc(ADDR_DRIVE, 8'h66, "locked write");
         end
      end
      wr(ADDR_DRIVE, 8'h60);
      rc(ADDR_DRIVE, 8'h60, "unlocked write");
      $display("test lock done");
   endtask
   task automatic t_faults();
      logic [15:0] r;
      int          p;
      wr(ADDR_PROT, 8'h44);
      chk({7'h0, faultPinN}, 8'h01, "no fault yet");
      wr(6'h3F, 8'h00);
      rc(ADDR_STATUS, 8'h01, "address fault");
      chk({7'h0, faultPinN}, 8'h00, "pin reports");
      u_spi_host_model.xfer(16'h8400, 15, r);
      rc(ADDR_STATUS, 8'h03, "framing fault");
      u_spi_host_model.xfer({1'b0, ADDR_PROT, 1'b0, 8'h46}, 17, r);
      rc(ADDR_PROT, 8'h44, "overrun write ignored");
      wr(ADDR_PROT, 8'h46);
      chk({7'h0, faultPinN}, 8'h01, "report off");
      p = pulseCnt;
      wr(ADDR_DRIVE, 8'h61);
      chk(8'(pulseCnt - p), 8'h01, "one clear pulse");
      rc(ADDR_DRIVE, 8'h60, "clear bit reads 0");
      rc(ADDR_STATUS, 8'h00, "flags cleared");
      @(posedge clk) overtempWarning <= 1'b1;
      repeat (6) @(posedge clk);
      #3 chk({7'h0, faultPinN}, 8'h01, "warning hidden");
      wr(ADDR_PROT, 8'h47);
      chk({7'h0, faultPinN}, 8'h00, "warning shown");
      @(posedge clk) overtempWarning <= 1'b0;
      repeat (6) @(posedge clk);
      #3 chk({7'h0, faultPinN}, 8'h01, "warning gone");
      $display("test faults done");
   endtask
   // Open drain reply still reads right through the pull-up
   task automatic t_sdo();
      wr(ADDR_DRIVE, 8'h40);
      odMode = 1'b1;
      rc(ADDR_PROT, 8'h47, "open drain read");
      chk(8'(odBad), 8'h00, "never drives high");
      odMode = 1'b0;
      wr(ADDR_DRIVE, 8'h60);
      rc(ADDR_DRIVE, 8'h60, "push pull back");
      $display("test sdo done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Watchdog: the sequence needs about 150 us
   initial begin
      #1000000;
      error_cnt++;
      print_verdict();
   end
   // Main sequence: reset for five cycles, then the scenarios
   initial begin
      rst_n <= 1'b0;   // Real falling edge, seen by both clock domains
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #3;
      t_reset();
      t_fields();
      t_lock();
      t_faults();
      t_sdo();
      print_verdict();
   end
endmodule
